// ===== core/scrc_pkg.sv
// Constants, types and helpers shared by the start-up clock and reset block
package scrc_pkg;

  // ==========================================================
  // Register map
  localparam logic [7:0] REG_PLL = 8'h00; // pll_control_register
  localparam logic [7:0] REG_RRST = 8'h04; // running_reset_control
  localparam logic [7:0] REG_STATUS = 8'h08; // block status, read only

  // ==========================================================
  // Field positions
  localparam int PLL_MULT_LSB = 0; // Multiplier field, 7 bits
  localparam int PLL_DIV_LSB = 8; // Divider field, 4 bits
  localparam int RRST_EN_BIT = 0; // Pin becomes running reset input
  localparam int ST_STATE_LSB = 0; // Sequencer state, 2 bits
  localparam int ST_RUN_BIT = 2; // Core executing
  localparam int ST_CFGERR_BIT = 3; // Reserved ratio code seen
  localparam int ST_BOOT_LSB = 4; // Sampled boot mode, 3 bits
  localparam int ST_CLKCFG_LSB = 8; // Sampled ratio code, 2 bits
  localparam int ST_RRST_BIT = 10; // Pin is in input mode

  // ==========================================================
  // Values after reset and counts
  localparam logic [6:0] RATIO_8 = 7'h08; // Code 00
  localparam logic [6:0] RATIO_32 = 7'h20; // Code 01
  localparam logic [6:0] RATIO_16 = 7'h10; // Code 10
  localparam logic [3:0] DIV_RESET = 4'h1; // Divider after strap load
  localparam logic [12:0] LOCK_CYCLES = 13'h1000; // 4096 reference cycles
  localparam logic [31:0] RESET_VECTOR = 32'h0000_0100; // Fetch start address

  // ==========================================================
  // Sequencer states
  typedef enum logic [1:0] {
    ST_HOLD, // Processor held in reset, straps sampled
    ST_LOCK, // Waiting for multiplier lock
    ST_RUN // Core fetching and executing
  } scrc_state_e;

  // Ratio code to multiplier; reserved code falls back to 8:1
  function automatic logic [6:0] scrc_ratio(input logic [1:0] code);
    case (code)
      2'h0: scrc_ratio = RATIO_8;
      2'h1: scrc_ratio = RATIO_32;
      2'h2: scrc_ratio = RATIO_16;
      default: scrc_ratio = RATIO_8;
    endcase
  endfunction

endpackage

// ===== core/scrc_lock_timer.sv
// Counter of reference clock edges that marks the end of the lock interval
module scrc_lock_timer
  import scrc_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clear,
  input wire logic tick,
  output logic done
);

  logic [12:0] cnt; // Reference edges seen since clear

  // ==========================================================
  // Edge counter, stops at the lock count
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= 13'h0000;
      done <= 1'b0;
    end else if (clear) begin
      cnt <= 13'h0000;
      done <= 1'b0;
    end else if (tick && !done) begin
      cnt <= cnt + 13'h0001;
      done <= (cnt + 13'h0001) == LOCK_CYCLES;
    end
  end

endmodule

// ===== core/scrc_top.sv
// Start-up sequencer: strap sampling, lock wait, reset pin and APB registers
module scrc_top
  import scrc_pkg::*;
(
  input wire logic CLK_SYS,
  input wire logic ARST_N,
  input wire logic REF_CLK_IN,
  input wire logic PROC_RESET_N,
  input wire logic [1:0] CLK_CFG,
  input wire logic [2:0] BOOT_CFG,
  input wire logic RST_PIN_I,
  output logic RST_PIN_O,
  output logic RST_PIN_OE,
  output logic CORE_RUN,
  output logic FETCH_GO,
  output logic [31:0] FETCH_ADDR,
  output logic [6:0] CLK_MULT,
  output logic [3:0] CLK_DIV,
  output logic [2:0] BOOT_MODE,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR
);

  // ==========================================================
  // Declarations
  logic rst_s1, rst_n; // Reset release chain
  logic ref_s1, ref_s2, ref_s3; // Reference clock sampler
  logic prst_s1, prst_s2; // Processor reset pin sampler
  logic rpin_s1, rpin_s2; // Running reset pin sampler
  logic [1:0] ccfg_s1, ccfg_s2; // Ratio strap sampler
  logic [2:0] boot_s1, boot_s2; // Boot strap sampler
  logic ref_tick; // One reference rising edge
  logic lock_done; // Lock interval complete
  scrc_state_e state; // Sequencer state
  scrc_state_e next_state; // Sequencer next state
  logic rrst_mode; // Pin in running reset input mode
  logic cfg_err; // Reserved ratio code sampled
  logic [1:0] ccfg_held; // Ratio code held from reset
  logic core_reset; // Any reset request this cycle
  logic apb_acc; // Access phase, first cycle
  logic wr_pll; // Accepted write to clock control
  logic wr_rrst; // Write to running reset control
  logic bad_addr; // Unmapped address
  logic [31:0] rd_word; // Read mux

  // ==========================================================
  // Reset release through two flip-flops
  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      rst_s1 <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_s1 <= 1'b1;
      rst_n <= rst_s1;
    end
  end

  // ==========================================================
  // Pin synchronisers, two flops each; the reference clock has a third flop for edge detection
  always_ff @(posedge CLK_SYS or negedge rst_n) begin
    if (!rst_n) begin
      ref_s1 <= 1'b0;
      ref_s2 <= 1'b0;
      ref_s3 <= 1'b0;
      prst_s1 <= 1'b0;
      prst_s2 <= 1'b0;
      rpin_s1 <= 1'b1;
      rpin_s2 <= 1'b1;
      ccfg_s1 <= 2'h0;
      ccfg_s2 <= 2'h0;
      boot_s1 <= 3'h0;
      boot_s2 <= 3'h0;
    end else begin
      ref_s1 <= REF_CLK_IN;
      ref_s2 <= ref_s1;
      ref_s3 <= ref_s2; // Edge history, second stage onward
      prst_s1 <= PROC_RESET_N;
      prst_s2 <= prst_s1;
      rpin_s1 <= RST_PIN_I;
      rpin_s2 <= rpin_s1;
      ccfg_s1 <= CLK_CFG;
      ccfg_s2 <= ccfg_s1;
      boot_s1 <= BOOT_CFG;
      boot_s2 <= boot_s1;
    end
  end

  // Rising edge of the reference clock
  assign ref_tick = ref_s2 && !ref_s3;

  // Pin reset, or running reset while the pin is an input
  assign core_reset = !prst_s2 || (rrst_mode && !rpin_s2);

  // ==========================================================
  // Lock interval timer
  scrc_lock_timer u_lock (
    .clk(CLK_SYS),
    .rst_n(rst_n),
    .clear(state == ST_HOLD),
    .tick(ref_tick),
    .done(lock_done)
  );

  // ==========================================================
  // Sequencer next state
  always_comb begin
    next_state = state;
    case (state)
      ST_HOLD: begin
        if (!core_reset) begin
          next_state = ST_LOCK;
        end
      end
      ST_LOCK: begin
        if (core_reset) begin
          next_state = ST_HOLD;
        end else if (lock_done) begin
          next_state = ST_RUN;
        end
      end
      ST_RUN: begin
        if (core_reset) begin
          next_state = ST_HOLD;
        end
      end
      default: begin
        next_state = ST_HOLD;
      end
    endcase
  end

  // Sequencer state register
  always_ff @(posedge CLK_SYS or negedge rst_n) begin
    if (!rst_n) begin
      state <= ST_HOLD;
    end else begin
      state <= next_state;
    end
  end

  // ==========================================================
  // Core start: run level and one-cycle fetch pulse at the vector
  always_ff @(posedge CLK_SYS or negedge rst_n) begin
    if (!rst_n) begin
      CORE_RUN <= 1'b0;
      FETCH_GO <= 1'b0;
      FETCH_ADDR <= RESET_VECTOR;
    end else begin
      CORE_RUN <= next_state == ST_RUN;
      FETCH_GO <= (state == ST_LOCK) && (next_state == ST_RUN);
      FETCH_ADDR <= RESET_VECTOR;
    end
  end

  // ==========================================================
  // Strap capture while reset is held; held afterwards
  always_ff @(posedge CLK_SYS or negedge rst_n) begin
    if (!rst_n) begin
      BOOT_MODE <= 3'h0;
      ccfg_held <= 2'h0;
      cfg_err <= 1'b0;
    end else if (state == ST_HOLD) begin
      BOOT_MODE <= boot_s2;
      ccfg_held <= ccfg_s2;
      cfg_err <= ccfg_s2 == 2'h3; // Reserved code flagged
    end
  end

  // ==========================================================
  // Clock control: strap ratio in reset, software value once running
  always_ff @(posedge CLK_SYS or negedge rst_n) begin
    if (!rst_n) begin
      CLK_MULT <= RATIO_8;
      CLK_DIV <= DIV_RESET;
    end else if (state == ST_HOLD) begin
      CLK_MULT <= scrc_ratio(ccfg_s2);
      CLK_DIV <= DIV_RESET;
    end else if (wr_pll) begin
      CLK_MULT <= PWDATA[PLL_MULT_LSB +: 7];
      CLK_DIV <= PWDATA[PLL_DIV_LSB +: 4];
    end
  end

  // ==========================================================
  // Pin mode control; pin reset restores output mode
  always_ff @(posedge CLK_SYS or negedge rst_n) begin
    if (!rst_n) begin
      rrst_mode <= 1'b0;
    end else if (!prst_s2) begin
      rrst_mode <= 1'b0;
    end else if (wr_rrst) begin
      rrst_mode <= PWDATA[RRST_EN_BIT];
    end
  end

  // Dual-function pin: drives reset state unless turned into input
  always_ff @(posedge CLK_SYS or negedge rst_n) begin
    if (!rst_n) begin
      RST_PIN_O <= 1'b0;
      RST_PIN_OE <= 1'b1;
    end else begin
      RST_PIN_O <= state == ST_RUN; // Low while core is held
      RST_PIN_OE <= !rrst_mode;
    end
  end

  // ==========================================================
  // APB decode; one wait state per access
  assign apb_acc = PSEL && PENABLE && !PREADY;
  assign bad_addr = (PADDR != REG_PLL) && (PADDR != REG_RRST) && (PADDR != REG_STATUS);
  assign wr_pll = apb_acc && PWRITE && (PADDR == REG_PLL) && (state == ST_RUN);
  assign wr_rrst = apb_acc && PWRITE && (PADDR == REG_RRST);

  // Read mux
  always_comb begin
    rd_word = 32'h0000_0000;
    case (PADDR)
      REG_PLL: begin
        rd_word[PLL_MULT_LSB +: 7] = CLK_MULT;
        rd_word[PLL_DIV_LSB +: 4] = CLK_DIV;
      end
      REG_RRST: begin
        rd_word[RRST_EN_BIT] = rrst_mode;
      end
      REG_STATUS: begin
        rd_word[ST_STATE_LSB +: 2] = state;
        rd_word[ST_RUN_BIT] = CORE_RUN;
        rd_word[ST_CFGERR_BIT] = cfg_err;
        rd_word[ST_BOOT_LSB +: 3] = BOOT_MODE;
        rd_word[ST_CLKCFG_LSB +: 2] = ccfg_held;
        rd_word[ST_RRST_BIT] = rrst_mode;
      end
      default: begin
        rd_word = 32'h0000_0000;
      end
    endcase
  end

  // Answer registers
  always_ff @(posedge CLK_SYS or negedge rst_n) begin
    if (!rst_n) begin
      PREADY <= 1'b0;
      PRDATA <= 32'h0000_0000;
      PSLVERR <= 1'b0;
    end else if (apb_acc) begin
      PREADY <= 1'b1;
      PRDATA <= PWRITE ? 32'h0000_0000 : rd_word;
      PSLVERR <= bad_addr || (PWRITE && (PADDR == REG_PLL) && (state != ST_RUN));
    end else begin
      PREADY <= 1'b0;
      PRDATA <= 32'h0000_0000;
      PSLVERR <= 1'b0;
    end
  end

  // ==========================================================
  // Checks
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (!rst_n);

  property p_strap_ratio;
    (state == ST_HOLD) |=> (CLK_MULT == scrc_ratio($past(ccfg_s2)));
  endproperty
  a_strap_ratio: assert property (p_strap_ratio)
    else $error("Multiplier does not follow ratio strap");

  property p_sw_override;
    wr_pll |=> (CLK_MULT == $past(PWDATA[6:0])) && (CLK_DIV == $past(PWDATA[11:8]));
  endproperty
  a_sw_override: assert property (p_sw_override)
    else $error("Clock control write not applied");

  property p_lock_idle;
    $rose(CORE_RUN) |-> $past(lock_done) && $past(state, 2) == ST_LOCK;
  endproperty
  a_lock_idle: assert property (p_lock_idle)
    else $error("Core started before lock interval ended");

  property p_no_run_in_lock;
    (state == ST_LOCK) && !lock_done |=> !CORE_RUN;
  endproperty
  a_no_run_in_lock: assert property (p_no_run_in_lock)
    else $error("Core ran during lock interval");

  property p_vector_fetch;
    $rose(CORE_RUN) |-> FETCH_GO && (FETCH_ADDR == RESET_VECTOR) ##1 !FETCH_GO;
  endproperty
  a_vector_fetch: assert property (p_vector_fetch)
    else $error("Start fetch missing or not at reset vector");

  property p_pin_output;
    !rrst_mode |=> RST_PIN_OE && (RST_PIN_O == $past(state == ST_RUN));
  endproperty
  a_pin_output: assert property (p_pin_output)
    else $error("Dual pin not acting as reset output");

  property p_pin_input;
    wr_rrst && PWDATA[0] && prst_s2 |=> rrst_mode ##1 !RST_PIN_OE;
  endproperty
  a_pin_input: assert property (p_pin_input)
    else $error("Dual pin did not become running reset input");

  property p_strap_hold;
    (state != ST_HOLD) |=> $stable(BOOT_MODE) && $stable(ccfg_held);
  endproperty
  a_strap_hold: assert property (p_strap_hold)
    else $error("Straps changed outside reset");

endmodule

// ===== testbench/scrc_board.sv
// Board model: reset supervisor, strap drivers and reference oscillator
module scrc_board (
  input wire logic clk,
  input wire logic hold_req,
  input wire logic run_rst_req,
  input wire logic [1:0] ratio,
  input wire logic [2:0] boot,
  input wire logic pin_oe,
  input wire logic pin_o,
  output logic proc_reset_n,
  output logic [1:0] clk_cfg,
  output logic [2:0] boot_cfg,
  output logic ref_clk,
  output logic pin_i
);
  timeunit 1ns;
  timeprecision 100ps;
  logic hold_d; // Reset request one cycle late

  // ==========================================================
  // Reference oscillator, never halted
  initial begin
    ref_clk = 1'b0;
    forever #24 ref_clk = ~ref_clk;
  end

  // ==========================================================
  // Straps settle one cycle before reset moves
  initial begin
    proc_reset_n = 1'b0;
    hold_d = 1'b1;
    clk_cfg = 2'h0;
    boot_cfg = 3'h0;
  end
  always @(posedge clk) begin
    clk_cfg <= ratio;
    boot_cfg <= boot;
    hold_d <= hold_req;
    proc_reset_n <= !hold_d;
  end

  // Pin level: device drive, else board pulls low or pull-up holds high
  assign pin_i = pin_oe ? pin_o : !run_rst_req;
endmodule

// ===== testbench/test_scrc_top.sv
// Self-checking bench of the start-up clock and reset block
module test_scrc_top;
  import scrc_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk, arst_n, hold, rrq, psel, pen, pwr, er;
  logic [1:0] ratio;
  logic [2:0] boot, exp_boot;
  logic [7:0] paddr;
  logic [31:0] pwdata, rd, rnd;
  logic proc_n, ref_clk, pin_i, pin_o, pin_oe, run, go, pready, pslverr;
  logic [1:0] cfg;
  logic [2:0] bcfg, bmode;
  logic [31:0] faddr, prdata;
  logic [6:0] mult;
  logic [3:0] div;
  int miscompares = 0;
  int check_count = 0;
  int refcnt = 0;
  int cyc = 0;
  int ratio_tab[4] = '{8, 32, 16, 8}; // Model of strap decode

  scrc_top u_scrc_top (.CLK_SYS(clk), .ARST_N(arst_n), .REF_CLK_IN(ref_clk),
    .PROC_RESET_N(proc_n), .CLK_CFG(cfg), .BOOT_CFG(bcfg), .RST_PIN_I(pin_i),
    .RST_PIN_O(pin_o), .RST_PIN_OE(pin_oe), .CORE_RUN(run), .FETCH_GO(go),
    .FETCH_ADDR(faddr), .CLK_MULT(mult), .CLK_DIV(div), .BOOT_MODE(bmode),
    .PSEL(psel), .PENABLE(pen), .PWRITE(pwr), .PADDR(paddr), .PWDATA(pwdata),
    .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr));
  scrc_board u_scrc_board (.clk(clk), .hold_req(hold), .run_rst_req(rrq),
    .ratio(ratio), .boot(boot), .pin_oe(pin_oe), .pin_o(pin_o),
    .proc_reset_n(proc_n), .clk_cfg(cfg), .boot_cfg(bcfg), .ref_clk(ref_clk),
    .pin_i(pin_i));

  // ==========================================================
  // Clock, timeout and reference edge count
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 40000) begin
      miscompares++;
      end_sim();
    end
  end
  always @(posedge ref_clk) refcnt++;
  // Lock window opens when the board lets go of the processor reset pin
  always @(posedge proc_n) refcnt = 0;

  // ==========================================================
  // Helpers
  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // APB transfer; answer taken at the rising edge where PREADY is seen high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwr <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
    if (n >= 20) miscompares++;
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    int n;
    arst_n = 1'b0;
    hold = 1'b1;
    rrq = 1'b0;
    ratio = 2'h0;
    boot = 3'h0;
    psel = 1'b0;
    pen = 1'b0;
    pwr = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    rnd = 32'h0001737f;
    repeat (3) @(posedge clk);
    arst_n <= 1'b1;
    // Every strap code, boot strap moved after release
    for (int c = 0; c < 5; c++) begin
      rnd = lfsr(rnd);
      exp_boot = rnd[2:0];
      ratio <= (c == 4) ? 2'h1 : 2'(c);
      boot <= exp_boot;
      hold <= 1'b1;
      repeat (8) @(posedge clk);
      hold <= 1'b0;
      repeat (6) @(posedge clk);
      boot <= ~exp_boot;
      if (c == 4) break;
      @(negedge clk);
      chk("mult", mult, ratio_tab[c]);
      chk("boot", bmode, exp_boot);
      chk("pin_oe", pin_oe, 1);
      chk("pin_o", pin_o, 0);
      apb(1'b0, 8'h08, 32'h0);
      chk("cfgerr", rd[3], c == 3);
      chk("status", {rd[9:8], rd[6:4], rd[2:0]}, {2'(c), exp_boot, 3'h1});
      apb(1'b1, 8'h00, 32'h0000_0f7f);
      chk("early_wr", er, 1);
      chk("idle", run, 0);
    end
    // Lock wait then start at the vector
    n = 0;
    do @(negedge clk); while (run !== 1'b1 && ++n < 30000);
    chk("lock", refcnt >= 4096 && refcnt <= 4097, 1);
    chk("go", go, 1);
    chk("vector", faddr, RESET_VECTOR);
    @(negedge clk);
    chk("pin_o_run", pin_o, 1);
    chk("go_pulse", go, 0);
    chk("boot_held", bmode, exp_boot);
    // Software clock override
    rnd = lfsr(rnd);
    apb(1'b1, 8'h00, {20'h0, rnd[11:8], 1'b0, rnd[6:0]});
    chk("wr_err", er, 0);
    @(negedge clk);
    chk("sw_mult", mult, rnd[6:0]);
    chk("sw_div", div, rnd[11:8]);
    apb(1'b0, 8'h0c, 32'h0);
    chk("unmapped", {er, rd[30:0]}, 32'h8000_0000);
    // Dual pin to running reset input
    apb(1'b1, 8'h04, 32'h1);
    repeat (3) @(negedge clk);
    chk("pin_in_mode", pin_oe, 0);
    @(posedge clk);
    rrq <= 1'b1;
    repeat (8) @(negedge clk);
    chk("run_reset", run, 0);
    chk("mult_reload", mult, ratio_tab[1]);
    @(posedge clk);
    rrq <= 1'b0;
    apb(1'b0, 8'h04, 32'h0);
    chk("mode_kept", rd[0], 1);
    end_sim();
  end
endmodule
